// >>> src/lcgs_gate3_select.sv
// Function
// - Select bit 6 gates inverted data 4 onto the gate 3 node.
// - Select bit 2 gates inverted data 2 onto the gate 3 node.
// - Select bit 1 gates true data 1 onto the gate 3 node.
// - Select bit 3 gates true data 2 onto the gate 3 node.
`include "lcgs_defs.svh"
`default_nettype none

module lcgs_gate3_select
   import lcgs_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [3:0] data_in,
   output logic [7:0] third_gate_node,
   output logic [7:0] gate3_input_select
);

   // ****************************************************************
   // State and decode signals
   // ****************************************************************
   lcgs_state_type state;
   lcgs_state_type next_state;
   logic [7:0] candidate;
   logic setup;
   logic access;
   logic hit_sel;
   logic sel_write;

   // Every select field and every data copy has a name of its own, so
   // that each gate input below reads as one field and one copy.
   logic g3_sel_d4_true;
   logic g3_sel_d4_inverted;
   logic g3_sel_d3_true;
   logic g3_sel_d3_inverted;
   logic g3_sel_d2_true;
   logic g3_sel_d2_inverted;
   logic g3_sel_d1_true;
   logic g3_sel_d1_inverted;

   logic data4_true_signal;
   logic data4_inverted_signal;
   logic data3_true_signal;
   logic data3_inverted_signal;
   logic data2_true_signal;
   logic data2_inverted_signal;
   logic data1_true_signal;
   logic data1_inverted_signal;

   // ****************************************************************
   // Gating helper
   // ****************************************************************
   // An input that is not selected is seen by the combining gate as a 0.
   function automatic logic lcgs_gate_bit(input logic enable, input logic copy);
      return enable & copy;
   endfunction : lcgs_gate_bit

   // ****************************************************************
   // Per-input candidate copies
   // ****************************************************************
   // Even select bits take the inverted copy, odd bits the true copy.
   genvar i;
   generate
      for (i = 0; i < 4; i++) begin : g_cand
         assign candidate[2*i] = ~data_in[i];
         assign candidate[2*i+1] = data_in[i];
      end
   endgenerate

   // ****************************************************************
   // Gate input pairs
   // ****************************************************************
   // d4 inverted pair
   assign data4_inverted_signal = candidate[`LCGS_BIT_D4_INV];
   assign g3_sel_d4_inverted = state.select[`LCGS_BIT_D4_INV];

   assign data2_inverted_signal = candidate[`LCGS_BIT_D2_INV];
   assign g3_sel_d2_inverted = state.select[`LCGS_BIT_D2_INV];

   assign data1_true_signal = candidate[`LCGS_BIT_D1_TRUE];
   assign g3_sel_d1_true = state.select[`LCGS_BIT_D1_TRUE];

   assign data2_true_signal = candidate[`LCGS_BIT_D2_TRUE];
   assign g3_sel_d2_true = state.select[`LCGS_BIT_D2_TRUE];

   assign data4_true_signal = candidate[`LCGS_BIT_D4_TRUE];
   assign g3_sel_d4_true = state.select[`LCGS_BIT_D4_TRUE];

   assign data3_true_signal = candidate[`LCGS_BIT_D3_TRUE];
   assign g3_sel_d3_true = state.select[`LCGS_BIT_D3_TRUE];

   assign data3_inverted_signal = candidate[`LCGS_BIT_D3_INV];
   assign g3_sel_d3_inverted = state.select[`LCGS_BIT_D3_INV];

   assign data1_inverted_signal = candidate[`LCGS_BIT_D1_INV];
   assign g3_sel_d1_inverted = state.select[`LCGS_BIT_D1_INV];

   // ****************************************************************
   // Bus decode
   // ****************************************************************
   // Only the low address bits are decoded, so the two words repeat
   // through the rest of the address space.
   assign setup = psel && !penable;
   assign access = psel && penable;
   assign hit_sel = paddr[`LCGS_ADDR_WIDTH-1:0] == `LCGS_ADDR_SELECT;
   assign sel_write = access && state.pready && pwrite && hit_sel && pstrb[0];

   // ****************************************************************
   // Next state
   // ****************************************************************
   // The node is registered one cycle behind the inputs so that every
   // output comes from a flip-flop; the combining gate sees it a cycle late.
   always_comb begin
      next_state = state;
      next_state.pready = 1'b0;
      next_state.pslverr = 1'b0;

      next_state.node[`LCGS_BIT_D4_INV] =
         lcgs_gate_bit(g3_sel_d4_inverted, data4_inverted_signal);

      next_state.node[`LCGS_BIT_D2_INV] =
         lcgs_gate_bit(g3_sel_d2_inverted, data2_inverted_signal);

      next_state.node[`LCGS_BIT_D1_TRUE] =
         lcgs_gate_bit(g3_sel_d1_true, data1_true_signal);

      next_state.node[`LCGS_BIT_D2_TRUE] =
         lcgs_gate_bit(g3_sel_d2_true, data2_true_signal);

      next_state.node[`LCGS_BIT_D4_TRUE] =
         lcgs_gate_bit(g3_sel_d4_true, data4_true_signal);

      next_state.node[`LCGS_BIT_D3_TRUE] =
         lcgs_gate_bit(g3_sel_d3_true, data3_true_signal);

      next_state.node[`LCGS_BIT_D3_INV] =
         lcgs_gate_bit(g3_sel_d3_inverted, data3_inverted_signal);

      next_state.node[`LCGS_BIT_D1_INV] =
         lcgs_gate_bit(g3_sel_d1_inverted, data1_inverted_signal);

      // The answer is prepared in the setup cycle so that every access
      // completes in exactly one access cycle.
      if (setup) begin
         next_state.pready = 1'b1;
         case (paddr[`LCGS_ADDR_WIDTH-1:0])
            `LCGS_ADDR_SELECT: begin
               next_state.prdata = {24'h00_0000, state.select};
            end
            `LCGS_ADDR_NODE: begin
               // The node word is read-only, so a write to it is refused.
               next_state.prdata = {24'h00_0000, state.node};
               next_state.pslverr = pwrite;
            end
            default: begin
               next_state.prdata = 32'h0000_0000;
               next_state.pslverr = 1'b1;
            end
         endcase
      end

      if (sel_write) begin
         next_state.select = pwdata[7:0];
      end
   end

   // ****************************************************************
   // State register
   // ****************************************************************
   // The select value has no defined state after reset in the target
   // hardware; a fixed zero is chosen so that no unknown ever reaches
   // the gate and software can rely on a clean start.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state.select <= `LCGS_SELECT_RESET;
         state.node <= 8'h00;
         state.prdata <= 32'h0000_0000;
         state.pready <= 1'b0;
         state.pslverr <= 1'b0;
      end else begin
         state <= next_state;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   // Every output is a plain copy of a flip-flop, so no decode glitch
   // can reach the pins.
   assign prdata = state.prdata;
   assign pready = state.pready;
   assign pslverr = state.pslverr;
   assign third_gate_node = state.node;
   assign gate3_input_select = state.select;

endmodule : lcgs_gate3_select

`default_nettype wire

// >>> src/lcgs_defs.svh
`ifndef LCGS_DEFS_SVH
`define LCGS_DEFS_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define LCGS_ADDR_SELECT 12'h000
`define LCGS_ADDR_NODE 12'h004
`define LCGS_ADDR_WIDTH 12

// ****************************************************************
// Select bit positions
// ****************************************************************
`define LCGS_BIT_D1_INV 0
`define LCGS_BIT_D1_TRUE 1
`define LCGS_BIT_D2_INV 2
`define LCGS_BIT_D2_TRUE 3
`define LCGS_BIT_D3_INV 4
`define LCGS_BIT_D3_TRUE 5
`define LCGS_BIT_D4_INV 6
`define LCGS_BIT_D4_TRUE 7

// ****************************************************************
// Reset values
// ****************************************************************
`define LCGS_SELECT_RESET 8'h00

`endif

// >>> src/lcgs_pkg.sv
`default_nettype none

package lcgs_pkg;

   typedef logic [7:0] lcgs_sel_type;

   typedef struct packed {
      lcgs_sel_type select;
      logic [7:0] node;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } lcgs_state_type;

endpackage : lcgs_pkg

`default_nettype wire

// >>> dv/lcgs_properties.sv
`default_nettype none
module lcgs_properties (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic pready,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [3:0] data_in,
   input wire logic [7:0] third_gate_node,
   input wire logic [7:0] gate3_input_select
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_wr;
      psel && penable && pwrite && pready && paddr[11:0] == 12'h000 && pstrb[0];
   endsequence
   property p_wr;
      s_wr |=> gate3_input_select == $past(pwdata[7:0]);
   endproperty
   a_wr: assert property (p_wr) else $error("select write lost");
   property p_d4n;
      third_gate_node[6] == $past(gate3_input_select[6] & ~data_in[3]);
   endproperty
   a_d4n: assert property (p_d4n) else $error("node bit 6 wrong");
   property p_d2n;
      third_gate_node[2] == $past(gate3_input_select[2] & ~data_in[1]);
   endproperty
   a_d2n: assert property (p_d2n) else $error("node bit 2 wrong");
   property p_d1t;
      third_gate_node[1] == $past(gate3_input_select[1] & data_in[0]);
   endproperty
   a_d1t: assert property (p_d1t) else $error("node bit 1 wrong");
   property p_d2t;
      third_gate_node[3] == $past(gate3_input_select[3] & data_in[1]);
   endproperty
   a_d2t: assert property (p_d2t) else $error("node bit 3 wrong");
   property p_d4t;
      third_gate_node[7] == $past(gate3_input_select[7] & data_in[3]);
   endproperty
   a_d4t: assert property (p_d4t) else $error("node bit 7 wrong");
   property p_d3t;
      third_gate_node[5] == $past(gate3_input_select[5] & data_in[2]);
   endproperty
   a_d3t: assert property (p_d3t) else $error("node bit 5 wrong");
   property p_d3n;
      third_gate_node[4] == $past(gate3_input_select[4] & ~data_in[2]);
   endproperty
   a_d3n: assert property (p_d3n) else $error("node bit 4 wrong");
   property p_d1n;
      third_gate_node[0] == $past(gate3_input_select[0] & ~data_in[0]);
   endproperty
   a_d1n: assert property (p_d1n) else $error("node bit 0 wrong");
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_answer;
      pready ##1 !pready;
   endsequence
   property p_answer;
      s_setup |=> s_answer;
   endproperty
   a_answer: assert property (p_answer) else $error("access not answered once");
   sequence s_masked_wr;
      psel && penable && pwrite && pready && !pstrb[0];
   endsequence
   property p_masked;
      s_masked_wr |=> $stable(gate3_input_select);
   endproperty
   a_masked: assert property (p_masked) else $error("masked write changed select");
endmodule : lcgs_properties
bind lcgs_gate3_select lcgs_properties u_props (.clk(clk), .rst_n(rst_n), .psel(psel),
   .penable(penable), .pwrite(pwrite), .pready(pready), .paddr(paddr), .pwdata(pwdata),
   .pstrb(pstrb), .data_in(data_in), .third_gate_node(third_gate_node),
   .gate3_input_select(gate3_input_select));
`default_nettype wire

// >>> dv/tb.sv
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
   logic [3:0] pstrb = 4'hF, data_in = 4'h0;
   logic pready, pslverr, err;
   logic [7:0] node, sel, cand;
   int fails = 0, cmp_count = 0;
   lcgs_gate3_select DUT (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .data_in(data_in), .third_gate_node(node),
      .gate3_input_select(sel));
   initial forever #5 clk = ~clk;
   task automatic final_report;
      if (fails == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : final_report
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %0t: got %h want %h", $time, got, exp);
      end
   endtask : check
   // ***********************************************
   // APB master: request held until pready is seen.
   // ***********************************************
   task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
      int n;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         fails++;
         final_report();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      apb(1'b0, 32'h0, 32'h0);
      check(rd, 32'h0);
      check({31'h0, err}, 32'h0);
      apb(1'b1, 32'h0, 32'hA5);
      check({24'h0, sel}, 32'hA5);
      apb(1'b0, 32'h0, 32'h0);
      check(rd, 32'hA5);
      pstrb <= 4'hE;
      apb(1'b1, 32'h0, 32'h5A);
      pstrb <= 4'hF;
      apb(1'b0, 32'h0, 32'h0);
      check(rd, 32'hA5);
      apb(1'b0, 32'h8, 32'h0);
      check({31'h0, err}, 32'h1);
      check(rd, 32'h0);
      for (int b = 0; b < 8; b++) begin
         apb(1'b1, 32'h0, 32'h1 << b);
         check({24'h0, sel}, 32'h1 << b);
         for (int d = 0; d < 16; d++) begin
            data_in <= d[3:0];
            repeat (2) @(posedge clk);
            cand = {data_in[3], ~data_in[3], data_in[2], ~data_in[2],
               data_in[1], ~data_in[1], data_in[0], ~data_in[0]};
            check({24'h0, node}, {24'h0, cand & (8'h01 << b)});
         end
      end
      apb(1'b0, 32'h4, 32'h0);
      check(rd, 32'h80);
      check({31'h0, err}, 32'h0);
      apb(1'b1, 32'h4, 32'hFF);
      check({31'h0, err}, 32'h1);
      apb(1'b0, 32'h0, 32'h0);
      check(rd, 32'h80);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      check({24'h0, sel}, 32'h0);
      check({24'h0, node}, 32'h0);
      final_report();
   end
endmodule : tb
`default_nettype wire
